// ### design/esb_loader.v
// EEPROM self-boot loader: parses the boot image and writes it into core memories.
// Assumes byte-level SPI and I2C engines on the master port, same clock, and an
// Avalon-MM master for the status and control registers.
// Behaviour
// - Boot-select high at reset release starts boot
// - Reset rising edge with boot-select restarts boot
// - Target-select low picks I2C, else SPI
// - SPI uses 16- or 24-bit byte addresses
// - SPI read command 0x03, mode 3, MSB first
// - SPI first transactions at 1 MHz or less
// - I2C device 0x50 with 16-bit memory addresses
// - I2C first transactions at 100 kHz or less
// - Three attempts, then fault and core sleep
// - Fault shown only in flag and cause registers; the status register also shows sleep and state
// - Image is header, blocks, then footer
// - Sixteen-byte header at zero, sentinel 0xAA
// - Continue from header's first-block address
// - Header carries clock-loop and EEPROM speed settings
// - Block is eight-byte descriptor plus word packets
// - Top descriptor bit marks final block; reserved ignored
// - Bank field picks data memory 0, 1, program
// - Write length words from base address upward
// - Jump address used only from final block
// - Footer checksum sums header, descriptors, payload words
// - Checksum mismatch faults; zero checksum skips check
// - Never enable SPI and I2C together
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "esb_consts.vh"
module esb_loader #(
  parameter ADDR_W = 18
) (
  input  wire              clk_i,
  input  wire              reset_n_i,
  input  wire              boot_select_pin_i,
  input  wire              reset_pin_i,
  input  wire              primary_target_select_i,
  output wire              mp_spi_en_o,
  output wire              mp_i2c_en_o,
  output wire              mp_spi_mode3_o,
  output wire [7:0]        mp_read_cmd_o,
  output wire [6:0]        mp_dev_addr_o,
  output wire [1:0]        mp_addr_bytes_o,
  output wire [15:0]       mp_half_period_o,
  output wire              mp_start_o,
  output wire              mp_stop_o,
  output wire [23:0]       mp_addr_o,
  input  wire              mp_byte_valid_i,
  input  wire [7:0]        mp_byte_i,
  output wire              mp_byte_ready_o,
  input  wire              mp_error_i,
  output wire              mem_we_o,
  output wire [1:0]        mem_bank_o,
  output wire [15:0]       mem_addr_o,
  output wire [31:0]       mem_data_o,
  output wire [7:0]        loop_input_divider_o,
  output wire [7:0]        loop_feedback_divider_o,
  output wire [7:0]        loop_config_sum_o,
  output wire [7:0]        clk_out_cfg_o,
  output wire [31:0]       eeprom_speed_cfg_o,
  output wire              core_run_o,
  output wire              core_sleep_o,
  output wire [15:0]       core_jump_addr_o,
  input  wire [ADDR_W-1:0] avs_address_i,
  input  wire              avs_read_i,
  input  wire              avs_write_i,
  input  wire [3:0]        avs_byteenable_i,
  input  wire [31:0]       avs_writedata_i,
  output wire [31:0]       avs_readdata_o,
  output wire              avs_waitrequest_o
);
  localparam ST_IDLE  = 4'h0;
  localparam ST_ISSUE = 4'h1;
  localparam ST_HDR   = 4'h2;
  localparam ST_DESC  = 4'h3;
  localparam ST_DATA  = 4'h4;
  localparam ST_FOOT  = 4'h5;
  localparam ST_CHECK = 4'h6;
  localparam ST_FAIL  = 4'h7;
  localparam ST_RUN   = 4'h8;
  localparam ST_SLEEP = 4'h9;

  reg sel_s1_r, sel_s2_r, rst_s1_r, rst_s2_r, rst_s3_r, tsel_s1_r, tsel_s2_r;
  reg [3:0]  state_r;
  reg [1:0]  attempts_r;
  reg        proto_spi_r;
  reg [15:0] widx_r;
  reg        last_r;
  reg [1:0]  bank_r;
  reg [15:0] base_r;
  reg [15:0] len_r;
  reg [15:0] jump_r;
  reg [31:0] foot_hi_r;
  reg [31:0] foot_lo_r;
  reg [23:0] first_addr_r;
  reg [7:0]  div_r, fb_r, cfg_sum_r, clk_out_r;
  reg [31:0] speed_r;
  reg        fault_flag_r;
  reg [15:0] cause_r;
  reg        run_r, sleep_r;
  reg [15:0] jump_out_r;
  reg        start_r, stop_r, fast_r;
  reg [23:0] addr_r;
  reg        mem_we_r;
  reg [1:0]  mem_bank_r;
  reg [15:0] mem_addr_r;
  reg [31:0] mem_data_r;
  reg        acc_clear_r, acc_align_r;
  reg        addr24_r, sw_start_r, ack_r;
  reg [31:0] rdata_r;

  wire [31:0] word;
  wire        word_valid;
  wire [63:0] sum;
  wire        streaming = (state_r == ST_HDR) || (state_r == ST_DESC) ||
                          (state_r == ST_DATA) || (state_r == ST_FOOT);
  wire        busy = (state_r != ST_IDLE) && (state_r != ST_RUN) && (state_r != ST_SLEEP);
  // Refusing bytes while a word is being decoded keeps a late byte out of a seek
  wire        byte_take = mp_byte_valid_i && mp_byte_ready_o;
  wire        boot_go = (rst_s2_r && !rst_s3_r && sel_s2_r) || sw_start_r;
  wire [1:0]  attempts_inc = attempts_r + 2'h1;
  wire [63:0] stored_sum = {foot_hi_r, foot_lo_r};
  wire [15:0] len_last = len_r - 16'h0001;

  // Pins come from outside the clock domain
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_s1_r  <= 1'b0;
      sel_s2_r  <= 1'b0;
      rst_s1_r  <= 1'b0;
      rst_s2_r  <= 1'b0;
      rst_s3_r  <= 1'b0;
      tsel_s1_r <= 1'b0;
      tsel_s2_r <= 1'b0;
    end else begin
      sel_s1_r  <= boot_select_pin_i;
      sel_s2_r  <= sel_s1_r;
      rst_s1_r  <= reset_pin_i;
      rst_s2_r  <= rst_s1_r;
      rst_s3_r  <= rst_s2_r;
      tsel_s1_r <= primary_target_select_i;
      tsel_s2_r <= tsel_s1_r;
    end
  end

  esb_word_acc #(
    .LANE_W (2),
    .SUM_W  (64)
  ) u_acc (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .clear_i      (acc_clear_r),
    .align_i      (acc_align_r),
    .byte_valid_i (byte_take),
    .byte_i       (mp_byte_i),
    .sum_en_i     (state_r != ST_FOOT),
    .word_o       (word),
    .word_valid_o (word_valid),
    .sum_o        (sum)
  );

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r      <= ST_IDLE;
      attempts_r   <= 2'h0;
      proto_spi_r  <= 1'b0;
      widx_r       <= 16'h0000;
      last_r       <= 1'b0;
      bank_r       <= 2'h0;
      base_r       <= 16'h0000;
      len_r        <= 16'h0000;
      jump_r       <= 16'h0000;
      foot_hi_r    <= 32'h00000000;
      foot_lo_r    <= 32'h00000000;
      first_addr_r <= 24'h000000;
      div_r        <= 8'h00;
      fb_r         <= 8'h00;
      cfg_sum_r    <= 8'h00;
      clk_out_r    <= 8'h00;
      speed_r      <= 32'h00000000;
      fault_flag_r <= 1'b0;
      cause_r      <= `ESB_CAUSE_NONE;
      run_r        <= 1'b0;
      sleep_r      <= 1'b0;
      jump_out_r   <= 16'h0000;
      start_r      <= 1'b0;
      stop_r       <= 1'b0;
      fast_r       <= 1'b0;
      addr_r       <= 24'h000000;
      mem_we_r     <= 1'b0;
      mem_bank_r   <= 2'h0;
      mem_addr_r   <= 16'h0000;
      mem_data_r   <= 32'h00000000;
      acc_clear_r  <= 1'b0;
      acc_align_r  <= 1'b0;
    end else begin
      start_r     <= 1'b0;
      stop_r      <= 1'b0;
      mem_we_r    <= 1'b0;
      acc_clear_r <= 1'b0;
      acc_align_r <= 1'b0;
      if (boot_go) begin
        // A new sequence abandons whatever was running, including a loaded program
        state_r      <= ST_ISSUE;
        attempts_r   <= 2'h0;
        proto_spi_r  <= tsel_s2_r;
        fault_flag_r <= 1'b0;
        cause_r      <= `ESB_CAUSE_NONE;
        run_r        <= 1'b0;
        sleep_r      <= 1'b0;
        stop_r       <= busy;
        fast_r       <= 1'b0;
        addr_r       <= 24'h000000;
        acc_clear_r  <= 1'b1;
      end else if (streaming && mp_error_i) begin
        state_r <= ST_FAIL;
        cause_r <= `ESB_CAUSE_PORT;
        stop_r  <= 1'b1;
      end else begin
        case (state_r)
          ST_ISSUE: begin
            start_r <= 1'b1;
            widx_r  <= 16'h0000;
            state_r <= fast_r ? ST_DESC : ST_HDR;
          end
          ST_HDR: begin
            if (word_valid) begin
              widx_r <= widx_r + 16'h0001;
              case (widx_r[1:0])
                2'h0: begin
                  first_addr_r <= word[23:0];
                  if (word[31:24] != `ESB_SENTINEL) begin
                    state_r <= ST_FAIL;
                    cause_r <= `ESB_CAUSE_SENTINEL;
                    stop_r  <= 1'b1;
                  end
                end
                2'h1: begin
                  div_r <= word[23:16];
                  fb_r  <= word[7:0];
                end
                2'h2: begin
                  cfg_sum_r <= word[23:16];
                  clk_out_r <= word[7:0];
                end
                default: begin
                  speed_r     <= word;
                  stop_r      <= 1'b1;
                  addr_r      <= first_addr_r;
                  fast_r      <= 1'b1;
                  acc_align_r <= 1'b1;
                  state_r     <= ST_ISSUE;
                end
              endcase
            end
          end
          ST_DESC: begin
            if (word_valid) begin
              if (widx_r == 16'h0000) begin
                // Reserved descriptor bits are deliberately not looked at
                last_r <= word[`ESB_LAST_BIT];
                bank_r <= word[`ESB_BANK_HI:`ESB_BANK_LO];
                base_r <= word[15:0];
                widx_r <= 16'h0001;
                if (word[`ESB_BANK_HI:`ESB_BANK_LO] == `ESB_BANK_RSVD) begin
                  state_r <= ST_FAIL;
                  cause_r <= `ESB_CAUSE_BANK;
                  stop_r  <= 1'b1;
                end
              end else begin
                len_r  <= word[31:16];
                widx_r <= 16'h0000;
                if (last_r) begin
                  jump_r <= word[15:0];
                end
                if (word[31:16] != 16'h0000) begin
                  state_r <= ST_DATA;
                end else begin
                  state_r <= last_r ? ST_FOOT : ST_DESC;
                end
              end
            end
          end
          ST_DATA: begin
            if (word_valid) begin
              mem_we_r   <= 1'b1;
              mem_bank_r <= bank_r;
              mem_addr_r <= base_r + widx_r;
              mem_data_r <= word;
              if (widx_r == len_last) begin
                widx_r  <= 16'h0000;
                state_r <= last_r ? ST_FOOT : ST_DESC;
              end else begin
                widx_r <= widx_r + 16'h0001;
              end
            end
          end
          ST_FOOT: begin
            if (word_valid) begin
              if (widx_r == 16'h0000) begin
                foot_hi_r <= word;
                widx_r    <= `ESB_PAIR_LAST_WORD;
              end else begin
                foot_lo_r <= word;
                stop_r    <= 1'b1;
                state_r   <= ST_CHECK;
              end
            end
          end
          ST_CHECK: begin
            if (stored_sum == 64'h0000000000000000 || stored_sum == sum) begin
              run_r      <= 1'b1;
              jump_out_r <= jump_r;
              state_r    <= ST_RUN;
            end else begin
              cause_r <= `ESB_CAUSE_CHECKSUM;
              state_r <= ST_FAIL;
            end
          end
          ST_FAIL: begin
            if (attempts_inc == `ESB_MAX_ATTEMPTS) begin
              fault_flag_r <= 1'b1;
              sleep_r      <= 1'b1;
              state_r      <= ST_SLEEP;
            end else begin
              attempts_r  <= attempts_inc;
              fast_r      <= 1'b0;
              addr_r      <= 24'h000000;
              acc_clear_r <= 1'b1;
              state_r     <= ST_ISSUE;
            end
          end
          ST_IDLE, ST_RUN, ST_SLEEP: begin
            state_r <= state_r;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register slave: one wait cycle, then the answer
  wire        req = avs_read_i || avs_write_i;
  wire [15:0] idx = avs_address_i[ADDR_W-1:2];
  wire        word_aligned = (avs_address_i[1:0] == 2'h0);
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (word_aligned) begin
      case (idx)
        `ESB_IDX_FAULT_FLAG:  rd_mux = {31'h00000000, fault_flag_r};
        `ESB_IDX_FAULT_CAUSE: rd_mux = {16'h0000, cause_r};
        `ESB_IDX_CTRL:        rd_mux = {30'h00000000, addr24_r, 1'b0};
        `ESB_IDX_STATUS:      rd_mux = {23'h000000, sleep_r, run_r, proto_spi_r,
                                        attempts_r, state_r};
        default:              rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r      <= 1'b0;
      rdata_r    <= 32'h00000000;
      addr24_r   <= `ESB_CTRL_ADDR24_RST;
      sw_start_r <= 1'b0;
    end else begin
      ack_r      <= req && !ack_r;
      sw_start_r <= 1'b0;
      if (avs_read_i && !ack_r) begin
        rdata_r <= rd_mux;
      end
      if (avs_write_i && ack_r && word_aligned && idx == `ESB_IDX_CTRL &&
          avs_byteenable_i[0]) begin
        addr24_r   <= avs_writedata_i[`ESB_CTRL_ADDR24_BIT];
        sw_start_r <= avs_writedata_i[`ESB_CTRL_START_BIT];
      end
    end
  end

  assign avs_waitrequest_o = req && !ack_r;
  assign avs_readdata_o    = rdata_r;

  assign mp_spi_en_o      = busy && proto_spi_r;
  assign mp_i2c_en_o      = busy && !proto_spi_r;
  assign mp_spi_mode3_o   = 1'b1;
  assign mp_read_cmd_o    = `ESB_SPI_READ_CMD;
  assign mp_dev_addr_o    = `ESB_I2C_DEV_ADDR;
  assign mp_addr_bytes_o  = (proto_spi_r && addr24_r) ? `ESB_ADDR_BYTES_24 :
                            `ESB_ADDR_BYTES_16;
  // Header is always fetched slow; only the image body runs at the fast rate
  assign mp_half_period_o = proto_spi_r ?
                            (fast_r ? `ESB_SPI_FAST_HALF : `ESB_SPI_SLOW_HALF) :
                            (fast_r ? `ESB_I2C_FAST_HALF : `ESB_I2C_SLOW_HALF);
  assign mp_start_o       = start_r;
  assign mp_stop_o        = stop_r;
  assign mp_addr_o        = addr_r;
  assign mp_byte_ready_o  = streaming && !word_valid;
  assign mem_we_o         = mem_we_r;
  assign mem_bank_o       = mem_bank_r;
  assign mem_addr_o       = mem_addr_r;
  assign mem_data_o       = mem_data_r;
  assign loop_input_divider_o    = div_r;
  assign loop_feedback_divider_o = fb_r;
  assign loop_config_sum_o       = cfg_sum_r;
  assign clk_out_cfg_o           = clk_out_r;
  assign eeprom_speed_cfg_o      = speed_r;
  assign core_run_o       = run_r;
  assign core_sleep_o     = sleep_r;
  assign core_jump_addr_o = jump_out_r;
endmodule

// ### inc/esb_consts.vh
// Constants for the EEPROM self-boot loader: timing, image layout, codes, register map.
// Assumes a 100 MHz core clock; included by the loader only, not by its word accumulator.
`ifndef ESB_CONSTS_VH
`define ESB_CONSTS_VH
`define ESB_CLK_HZ          100000000
`define ESB_SPI_SLOW_HZ     1000000
`define ESB_I2C_SLOW_HZ     100000
// Slow half periods are half the ratios of the clock to the rates above, rounded up so the slow clocks never
// exceed their ceiling, and sized to the 16-bit half-period port
`define ESB_SPI_SLOW_HALF   16'h0032
`define ESB_I2C_SLOW_HALF   16'h01F4
`define ESB_SPI_FAST_HALF   16'h0003
`define ESB_I2C_FAST_HALF   16'h007D
`define ESB_SPI_READ_CMD    8'h03
`define ESB_I2C_DEV_ADDR    7'h50
`define ESB_ADDR_BYTES_16   2'h2
`define ESB_ADDR_BYTES_24   2'h3
`define ESB_SENTINEL        8'hAA
`define ESB_HDR_LAST_WORD   16'h0003
`define ESB_PAIR_LAST_WORD  16'h0001
`define ESB_MAX_ATTEMPTS    2'h3
`define ESB_LAST_BIT        31
`define ESB_BANK_HI         17
`define ESB_BANK_LO         16
`define ESB_BANK_RSVD       2'h3
`define ESB_CAUSE_NONE      16'h0000
`define ESB_CAUSE_SENTINEL  16'h0001
`define ESB_CAUSE_PORT      16'h0002
`define ESB_CAUSE_CHECKSUM  16'h0003
`define ESB_CAUSE_BANK      16'h0004
`define ESB_IDX_FAULT_FLAG  16'hF427
`define ESB_IDX_FAULT_CAUSE 16'hF428
`define ESB_IDX_CTRL        16'hF429
`define ESB_IDX_STATUS      16'hF42A
`define ESB_CTRL_START_BIT  0
`define ESB_CTRL_ADDR24_BIT 1
`define ESB_CTRL_ADDR24_RST 1'b0
`endif

// ### design/esb_word_acc.v
// Word assembler and running sum for the boot byte stream.
// Assumes bytes arrive in EEPROM order on the loader clock, one per accepted beat.
`timescale 1ns/1ns
module esb_word_acc #(
  parameter LANE_W = 2,
  parameter SUM_W  = 64
) (
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  input  wire                    clear_i,
  input  wire                    align_i,
  input  wire                    byte_valid_i,
  input  wire [7:0]              byte_i,
  input  wire                    sum_en_i,
  output wire [(8<<LANE_W)-1:0]  word_o,
  output wire                    word_valid_o,
  output wire [SUM_W-1:0]        sum_o
);
  localparam WORD_W = 8 << LANE_W;

  reg [LANE_W-1:0] lane_r;
  reg [WORD_W-1:0] word_r;
  reg              valid_r;
  reg [SUM_W-1:0]  sum_r;
  wire [WORD_W-1:0] word_nxt = {word_r[WORD_W-9:0], byte_i};
  wire              last_lane = &lane_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lane_r  <= {LANE_W{1'b0}};
      word_r  <= {WORD_W{1'b0}};
      valid_r <= 1'b0;
      sum_r   <= {SUM_W{1'b0}};
    end else begin
      valid_r <= 1'b0;
      if (clear_i || align_i) begin
        lane_r <= {LANE_W{1'b0}};
        if (clear_i) begin
          sum_r <= {SUM_W{1'b0}};
        end
      end else if (byte_valid_i) begin
        word_r <= word_nxt;
        lane_r <= lane_r + {{(LANE_W-1){1'b0}}, 1'b1};
        if (last_lane) begin
          valid_r <= 1'b1;
          if (sum_en_i) begin
            sum_r <= sum_r + {{(SUM_W-WORD_W){1'b0}}, word_nxt};
          end
        end
      end
    end
  end

  assign word_o       = word_r;
  assign word_valid_o = valid_r;
  assign sum_o        = sum_r;
endmodule

// ### sim/esb_chk.sv
// Checker for the self-boot loader: port relations of the master port and boot outcome.
// Assumes it is bound into esb_loader and sees only that module's ports.
`timescale 1ns/1ns
module esb_chk (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        mp_spi_en_o,
  input wire logic        mp_i2c_en_o,
  input wire logic        mp_spi_mode3_o,
  input wire logic [7:0]  mp_read_cmd_o,
  input wire logic [6:0]  mp_dev_addr_o,
  input wire logic [1:0]  mp_addr_bytes_o,
  input wire logic [15:0] mp_half_period_o,
  input wire logic        mp_start_o,
  input wire logic        mp_stop_o,
  input wire logic [23:0] mp_addr_o,
  input wire logic        mem_we_o,
  input wire logic [1:0]  mem_bank_o,
  input wire logic        core_run_o,
  input wire logic        core_sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire busy = mp_spi_en_o | mp_i2c_en_o;
  sequence s_open;
    mp_start_o && mp_addr_o == 24'h0;
  endsequence
  sequence s_quiet;
    !mem_we_o [*3];
  endsequence
  a_one_port: assert property (!(mp_spi_en_o && mp_i2c_en_o))
    else $error("both serial ports enabled");
  a_open_zero: assert property ($rose(busy) |-> ##1 s_open)
    else $error("boot did not open at address zero");
  a_slow_first: assert property (s_open |-> mp_half_period_o ==
    (mp_spi_en_o ? 16'h0032 : 16'h01F4)) else $error("header read not slow");
  a_fast_later: assert property (mp_start_o && mp_addr_o != 24'h0 |->
    mp_half_period_o == (mp_spi_en_o ? 16'h0003 : 16'h007D)) else $error("bulk read not fast");
  a_fixed_proto: assert property (mp_spi_mode3_o && mp_read_cmd_o == 8'h03 &&
    mp_dev_addr_o == 7'h50) else $error("protocol constants wrong");
  a_i2c_addr16: assert property (mp_i2c_en_o |-> mp_addr_bytes_o == 2'h2)
    else $error("i2c address not two bytes");
  a_word_gap: assert property (mem_we_o |=> s_quiet)
    else $error("memory writes closer than one packet");
  a_bank_legal: assert property (mem_we_o |-> mem_bank_o != 2'h3 && busy)
    else $error("bad memory write");
  a_body_reopen: assert property (mp_start_o && mp_addr_o != 24'h0 |->
    $past(mp_stop_o)) else $error("body read not preceded by a stop");
  a_run_idle: assert property ($rose(core_run_o) |-> !busy)
    else $error("run while port busy");
  a_end_excl: assert property (!(core_run_o && core_sleep_o))
    else $error("run and sleep together");
endmodule

// ### sim/esb_eeprom_model.sv
// Behavioural EEPROM plus byte engine on the master port: streams bytes from a start address.
// Assumes the bench fills mem; slow_i halves the byte rate.
`timescale 1ns/1ns
module esb_eeprom_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        ready_i,
  output wire logic        valid_o,
  output wire logic [7:0]  byte_o
);
  logic [7:0]  mem [0:255]; // Image lives in the part at 0x50
  logic [23:0] ptr = 24'h0;
  logic        on  = 1'h0;
  logic        ph  = 1'h0;
  // Sequential read, bytes as stored MSB first
  always @(posedge clk_i) begin
    ph <= ~ph;
    if (start_i) begin
      ptr <= addr_i;
      on  <= 1'h1;
    end else if (stop_i)
      on <= 1'h0;
    else if (valid_o && ready_i)
      ptr <= ptr + 24'h1;
  end
  assign valid_o = on && (!slow_i || ph);
  // Between bytes the lines carry junk, the inverted next byte
  assign byte_o = valid_o ? mem[ptr[7:0]] : ~mem[ptr[7:0]];
endmodule

// ### sim/esb_loader_tb.sv
// Testbench for the self-boot loader: pins, register bus and a byte-stream EEPROM model.
// Assumes esb_chk and esb_eeprom_model are compiled first.
`timescale 1ns/1ns
module esb_loader_tb;
  logic clk_i = 1'h0, reset_n_i = 1'h0, boot_select_pin_i = 1'h1, reset_pin_i = 1'h1;
  logic primary_target_select_i = 1'h1, mp_error_i = 1'h0, slow = 1'h0;
  logic avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [17:0] avs_address_i = 18'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  wire mp_spi_en_o, mp_i2c_en_o, mp_start_o, mp_stop_o, mp_byte_valid_i, mp_byte_ready_o;
  wire mem_we_o, core_run_o, core_sleep_o, avs_waitrequest_o;
  wire [1:0] mp_addr_bytes_o, mem_bank_o;
  wire [7:0] mp_byte_i, loop_input_divider_o, loop_feedback_divider_o, loop_config_sum_o;
  wire [7:0] clk_out_cfg_o;
  wire [15:0] mem_addr_o, core_jump_addr_o;
  wire [23:0] mp_addr_o;
  wire [31:0] mem_data_o, eeprom_speed_cfg_o, avs_readdata_o;
  int err_count = 0, n_tests = 0, n0 = 0, cyc = 0;
  logic [23:0] last_sa;
  logic [63:0] sum;
  logic [49:0] wq[$];
  logic [31:0] img [0:13] = '{32'hAA000014, 32'h00110022, 32'h00330044, 32'h89ABCDEF,
    32'h7FFC0300, 32'h00010000, 32'h11112222, 32'h00010100, 32'h00020000, 32'hDEADBEEF,
    32'h00000001, 32'h80020020, 32'h00010040, 32'hFFFFFFFF};
  logic [49:0] ew [0:3] = '{{2'h0, 16'h0300, 32'h11112222}, {2'h1, 16'h0100, 32'hDEADBEEF},
    {2'h1, 16'h0101, 32'h00000001}, {2'h2, 16'h0020, 32'hFFFFFFFF}};

  esb_loader uut (.clk_i, .reset_n_i, .boot_select_pin_i, .reset_pin_i,
    .primary_target_select_i, .mp_spi_en_o, .mp_i2c_en_o, .mp_spi_mode3_o(), .mp_read_cmd_o(),
    .mp_dev_addr_o(), .mp_addr_bytes_o, .mp_half_period_o(), .mp_start_o, .mp_stop_o,
    .mp_addr_o, .mp_byte_valid_i, .mp_byte_i, .mp_byte_ready_o, .mp_error_i, .mem_we_o,
    .mem_bank_o, .mem_addr_o, .mem_data_o, .loop_input_divider_o, .loop_feedback_divider_o,
    .loop_config_sum_o, .clk_out_cfg_o, .eeprom_speed_cfg_o, .core_run_o, .core_sleep_o,
    .core_jump_addr_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i(4'hF),
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);
  esb_eeprom_model eep (.clk_i, .slow_i(slow), .start_i(mp_start_o), .stop_i(mp_stop_o),
    .addr_i(mp_addr_o), .ready_i(mp_byte_ready_o), .valid_o(mp_byte_valid_i),
    .byte_o(mp_byte_i));

  initial forever #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (mem_we_o) wq.push_back({mem_bank_o, mem_addr_o, mem_data_o});
    if (mp_start_o) last_sa <= mp_addr_o;
    if (mp_start_o && mp_addr_o == 24'h0) n0++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task chk(input string nm, input logic [49:0] got, input logic [49:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task av(input logic w, input logic [17:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask

  task pw(input int a, input logic [31:0] w, input logic add);
    for (int i = 0; i < 4; i++) eep.mem[a + i] = w[31 - 8 * i -: 8];
    if (add) sum += {32'h0, w};
  endtask

  // Image with a gap word before the first block; k picks the fault planted
  task build(input int k);
    logic [31:0] w;
    sum = 64'h0;
    pw(16, 32'h5A5A5A5A, 1'h0);
    for (int i = 0; i < 14; i++) begin
      w = img[i];
      if (i == 0 && k == 3) w[31:24] = 8'h55;
      if (i == 7 && k == 4) w[17:16] = 2'h3;
      pw((i < 4) ? 4 * i : 4 * i + 4, w, 1'h1);
    end
    pw(60, (k == 1) ? 32'h0 : sum[63:32], 1'h0);
    pw(64, (k == 1) ? 32'h0 : sum[31:0] + ((k == 2) ? 32'h1 : 32'h0), 1'h0);
  endtask

  // how: 0 power-up, 1 reset pin pulse, 2 control start, 3 control start plus port error
  task boot(input int k, input int how, input logic ok, input int n_at, input logic [15:0] c);
    logic [31:0] q;
    build(k);
    wq.delete();
    n0 = 0;
    if (how == 1) begin
      @(posedge clk_i) reset_pin_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      reset_pin_i <= 1'h1;
    end else if (how >= 2)
      av(1'h1, 18'h3D0A4, 32'h1, q);
    while (!(mp_spi_en_o === 1'h1 || mp_i2c_en_o === 1'h1)) @(posedge clk_i);
    if (how == 3) begin
      repeat (20) @(posedge clk_i);
      mp_error_i <= 1'h1;
      @(posedge clk_i) mp_error_i <= 1'h0;
    end
    while (!(core_run_o === 1'h1 || core_sleep_o === 1'h1)) @(posedge clk_i);
    chk("run", core_run_o, ok);
    chk("sleep", core_sleep_o, !ok);
    chk("attempts", n0, n_at);
    av(1'h0, 18'h3D09C, 32'h0, q);
    chk("fault flag", q, {31'h0, !ok});
    av(1'h0, 18'h3D0A8, 32'h0, q);
    chk("port", q[6], primary_target_select_i);
    av(1'h0, 18'h3D0A0, 32'h0, q);
    chk("fault cause", q, c);
    if (ok) begin
      chk("jump", core_jump_addr_o, 16'h0040);
      chk("first block", last_sa, 24'h000014);
      chk("writes", wq.size(), 4);
      foreach (ew[i]) chk("write", wq[i], ew[i]);
      chk("loop", {loop_input_divider_o, loop_feedback_divider_o, loop_config_sum_o,
        clk_out_cfg_o}, 32'h11223344);
      chk("speed", eeprom_speed_cfg_o, 32'h89ABCDEF);
    end
    $display("Test %0d done", k);
  endtask

  task tally_and_finish;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    logic [31:0] q;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'h1;
    boot(0, 0, 1'h1, 1, 16'h0);
    boot_select_pin_i <= 1'h0;
    reset_pin_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    reset_pin_i <= 1'h1;
    repeat (20) @(posedge clk_i);
    chk("no boot", n0, 1);
    boot_select_pin_i <= 1'h1;
    av(1'h1, 18'h3D0A4, 32'h2, q);
    av(1'h0, 18'h3D0A4, 32'h0, q);
    chk("addr24", q, 32'h2);
    chk("addr bytes", mp_addr_bytes_o, 2'h3);
    av(1'h0, 18'h00100, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("Test registers done");
    boot(1, 1, 1'h1, 1, 16'h0);
    primary_target_select_i <= 1'h0;
    slow <= 1'h1;
    boot(2, 2, 1'h0, 3, 16'h0003);
    boot(3, 2, 1'h0, 3, 16'h0001);
    boot(4, 2, 1'h0, 3, 16'h0004);
    av(1'h1, 18'h3D09C, 32'h0, q);
    av(1'h0, 18'h3D09C, 32'h0, q);
    chk("flag read only", q, 32'h1);
    $display("Test read only flag done");
    // A port error in the first attempt leaves its cause behind after the retry succeeds
    boot(0, 3, 1'h1, 2, 16'h0002);
    tally_and_finish;
  end
endmodule

bind esb_loader esb_chk u_chk (.clk_i, .reset_n_i, .mp_spi_en_o, .mp_i2c_en_o, .mp_spi_mode3_o,
  .mp_read_cmd_o, .mp_dev_addr_o, .mp_addr_bytes_o, .mp_half_period_o, .mp_start_o, .mp_addr_o,
  .mem_we_o, .mem_bank_o, .core_run_o, .core_sleep_o, .mp_stop_o);
